// ==== design/cfi_host_defs.svh ====
/*
 * Constants for the query-mode host controller: command words, command
 * addresses, query table window and strobe timing counts.
 * Assumes a 25 MHz core clock and a word-wide parallel flash bus.
 */
// How it works
// R01: Write 98h at 55h/AAh enters query
// R02: Host drives word address bits A7 up zero
// R03: Reset command returns array-read device to array
// R04: Query also accepted from autoselect mode
// R05: Reset from autoselect-entered query returns autoselect
// R06: Entries 10h-12h give ASCII identification string
// R07: Entries 13h-14h give primary command set
// R08: Entries 15h-16h point to extended table
// R09: Entries 17h-1Ah report no alternates
// R10: Entries 1Bh-1Eh give supply voltage figures
// R11: Entry 1Fh gives word write timeout
// R12: Buffered write entries read zero
// R13: Entry 21h gives block erase timeout
// R14: Chip erase timeout entries read zero
// R15: Entries 23h, 25h give maximum multipliers
// R16: Entry 27h gives device size exponent
// R17: Entries 28h-29h give interface type
// R18: Entry 2Ch gives erase region count
// R19: Entries 2Dh-30h describe region one
// R20: Entries 31h-34h describe region two
// R21: Entries 35h-38h describe region three
// R22: Entries 39h-3Ch describe region four
// R23: Bad command sequence resets device to array
// R24: Byte mode doubles addresses, low byte only
`ifndef CFI_HOST_DEFS_SVH
`define CFI_HOST_DEFS_SVH

`define CMD_QUERY        16'h0098
`define CMD_RESET        16'h00f0
`define ADDR_QUERY_WORD  20'h00055
`define ADDR_QUERY_BYTE  20'h000aa
`define ADDR_RESET       20'h00000
`define QUERY_FIRST      6'h10
`define QUERY_LAST       6'h3c
`define QUERY_WORDS      45
// Strobe phase length in ns; a safe default, shorten for faster parts
`define STROBE_NS        80
`define CLK_NS           40
`define STROBE_CYC       ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ==== design/cfi_host_pkg.sv ====
/*
 * Types shared by the query host controller and its table memory.
 * Assumes nothing beyond the constant header.
 */
package cfi_host_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WRITE = 3'b001,
        ST_READ  = 3'b011,
        ST_NEXT  = 3'b111,
        ST_RSET  = 3'b110,
        ST_DONE  = 3'b100
    } host_state_t;
endpackage

// ==== design/cfi_table_if.sv ====
/*
 * Carrier between the controller and the table memory: a write port
 * that stores each query word as it is captured and a read port.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/1ps
interface cfi_table_if;
    logic        wr_en;
    logic [5:0]  wr_idx;
    logic [15:0] wr_data;
    logic [5:0]  rd_idx;
    logic [15:0] rd_data;
    modport ctrl (output wr_en, output wr_idx, output wr_data,
                  output rd_idx, input rd_data);
    modport mem  (input wr_en, input wr_idx, input wr_data,
                  input rd_idx, output rd_data);
endinterface

// ==== design/cfi_table_mem.sv ====
/*
 * Small memory that keeps the captured query table, one word per entry.
 * Assumes synchronous writes and a registered read port.
 */
`timescale 1ns/1ps
module cfi_table_mem
    import cfi_host_pkg::*;
(
    input  wire logic core_clk_in,
    cfi_table_if.mem  tbl
);
    logic [15:0] mem_reg [0:63];
    logic [15:0] rd_reg;

    // Store captured entries, registered read keeps timing clean
    always_ff @(posedge core_clk_in) begin
        if (tbl.wr_en) begin
            mem_reg[tbl.wr_idx] <= tbl.wr_data;
        end
        rd_reg <= mem_reg[tbl.rd_idx];
    end
    assign tbl.rd_data = rd_reg;
endmodule // cfi_table_mem

// ==== design/cfi_query_host.sv ====
/*
 * Host controller that drives a parallel NOR flash through its pins:
 * it writes the query command, walks the query table from 10h to 3Ch,
 * stores every word and then writes the reset command.
 * Assumes the flash data bus reaches this clock domain asynchronously,
 * so returned data passes two flip-flops before it is sampled.
 */
`timescale 1ns/1ps
`include "cfi_host_defs.svh"
module cfi_query_host
    import cfi_host_pkg::*;
#(
    parameter int STROBE_CYCLES = `STROBE_CYC
)(
    input  wire logic        core_clk_in,
    input  wire logic        nrst_in,
    input  wire logic        start_in,
    input  wire logic        byte_mode_in,
    input  wire logic        from_autoselect_in,
    input  wire logic [5:0]  rd_idx_in,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic             dq_oe_n_out,
    output logic      [19:0] addr_out,
    output logic             ce_n_out,
    output logic             oe_n_out,
    output logic             we_n_out,
    output logic             busy_out,
    output logic             done_out,
    output logic             mode_ok_out,
    output logic      [15:0] rd_data_out
);
    host_state_t state_reg;
    host_state_t state_next;
    logic [3:0]  cnt_reg;
    logic [5:0]  idx_reg;
    logic [15:0] dq_s1_reg;
    logic [15:0] dq_s2_reg;
    logic        phase_end;
    logic        auto_reg;
    logic        sig_ok_reg;

    cfi_table_if tbl ();

    cfi_table_mem u_mem (
        .core_clk_in (core_clk_in),
        .tbl         (tbl)
    );

    assign phase_end = (cnt_reg == 4'(STROBE_CYCLES + 1));

    // Two-stage capture of the asynchronous data bus
    always_ff @(posedge core_clk_in) begin
        dq_s1_reg <= dq_in;
        dq_s2_reg <= dq_s1_reg;
    end

    // Next state along the Gray path idle-write-read-next-reset-done
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:  if (start_in) state_next = ST_WRITE;
            ST_WRITE: if (phase_end) state_next = ST_READ;
            ST_READ:  if (phase_end) state_next = ST_NEXT;
            ST_NEXT:  state_next = (idx_reg == `QUERY_LAST) ?
                                   ST_RSET : ST_READ;
            ST_RSET:  if (phase_end) state_next = ST_DONE;
            ST_DONE:  state_next = ST_IDLE;
            // The two spare codes can only come from an upset: go idle
            default:  state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Phase counter; the extra cycles cover the data synchroniser
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in || state_reg != state_next || state_reg == ST_NEXT) begin
            cnt_reg <= 4'h0;
        end else if (state_reg != ST_IDLE && state_reg != ST_DONE) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end

    // Table index walks 10h..3Ch
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in || state_reg == ST_IDLE) begin
            idx_reg <= `QUERY_FIRST;
        end else if (state_reg == ST_NEXT) begin
            idx_reg <= idx_reg + 6'h01;
        end
    end

    // Remember whether the device came from autoselect; no status output reads the flag
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            auto_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && start_in) begin
            auto_reg <= from_autoselect_in; // R04
        end
    end

    // Bus pins; write pulse is low for the first STROBE_CYCLES phase cycles, high for the last two
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            addr_out    <= 20'h00000;
            dq_out      <= 16'h0000;
            dq_oe_n_out <= 1'b1;
            ce_n_out    <= 1'b1;
            oe_n_out    <= 1'b1;
            we_n_out    <= 1'b1;
        end else begin
            unique case (state_next)
                ST_WRITE: begin
                    // Query command at the mode-dependent address
                    addr_out    <= byte_mode_in ? `ADDR_QUERY_BYTE
                                                : `ADDR_QUERY_WORD; // R01
                    dq_out      <= `CMD_QUERY; // R01
                    dq_oe_n_out <= 1'b0;
                    ce_n_out    <= 1'b0;
                    oe_n_out    <= 1'b1;
                    we_n_out    <= (cnt_reg >= 4'(STROBE_CYCLES - 1));
                end
                ST_RSET: begin
                    addr_out    <= `ADDR_RESET;
                    dq_out      <= `CMD_RESET; // R03 R05
                    dq_oe_n_out <= 1'b0;
                    ce_n_out    <= 1'b0;
                    oe_n_out    <= 1'b1;
                    we_n_out    <= (cnt_reg >= 4'(STROBE_CYCLES - 1));
                end
                ST_READ, ST_NEXT: begin
                    // Upper word address bits held zero; byte mode doubles
                    addr_out    <= byte_mode_in ?
                                   {13'h0, idx_reg, 1'b0} :
                                   {14'h0, idx_reg}; // R02 R24
                    dq_oe_n_out <= 1'b1;
                    ce_n_out    <= 1'b0;
                    oe_n_out    <= 1'b0;
                    we_n_out    <= 1'b1;
                end
                default: begin
                    dq_oe_n_out <= 1'b1;
                    ce_n_out    <= 1'b1;
                    oe_n_out    <= 1'b1;
                    we_n_out    <= 1'b1;
                end
            endcase
        end
    end

    // Store each entry at the end of its read phase; byte mode masks high
    assign tbl.wr_en   = (state_reg == ST_READ) && phase_end;
    assign tbl.wr_idx  = idx_reg;
    assign tbl.wr_data = byte_mode_in ? {8'h00, dq_s2_reg[7:0]}
                                      : dq_s2_reg; // R24
    assign tbl.rd_idx  = rd_idx_in;

    // Check the identification string; a mismatch means the command
    // was refused and the device stayed in array read
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in || (state_reg == ST_IDLE && start_in)) begin
            sig_ok_reg <= 1'b1;
        end else if (tbl.wr_en) begin
            if ((idx_reg == 6'h10 && tbl.wr_data != 16'h0051) ||
                (idx_reg == 6'h11 && tbl.wr_data != 16'h0052) ||
                (idx_reg == 6'h12 && tbl.wr_data != 16'h0059)) begin
                sig_ok_reg <= 1'b0; // R06 R23
            end
        end
    end

    // Status outputs
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            busy_out    <= 1'b0;
            done_out    <= 1'b0;
            mode_ok_out <= 1'b0;
            rd_data_out <= 16'h0000;
        end else begin
            busy_out    <= (state_next != ST_IDLE && state_next != ST_DONE);
            done_out    <= (state_next == ST_DONE);
            mode_ok_out <= (state_next == ST_DONE) ? sig_ok_reg : mode_ok_out;
            rd_data_out <= tbl.rd_data;
        end
    end

    // Command strobe is never active together with output enable
    property p_no_contention;
        @(posedge core_clk_in) disable iff (!nrst_in)
        !(!we_n_out && !oe_n_out);
    endproperty
    a_no_contention: assert property (p_no_contention) // R01
        else $error("write and read strobes both active");

    property p_query_addr;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (!we_n_out && dq_out == `CMD_QUERY) |->
        (addr_out == (byte_mode_in ? `ADDR_QUERY_BYTE : `ADDR_QUERY_WORD));
    endproperty
    a_query_addr: assert property (p_query_addr) // R01
        else $error("query command at wrong address");

    property p_upper_zero;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (!oe_n_out && !byte_mode_in) |-> (addr_out[19:7] == 13'h0000);
    endproperty
    a_upper_zero: assert property (p_upper_zero) // R02
        else $error("upper address bits not zero in query read");

    property p_reset_before_done;
        @(posedge core_clk_in) disable iff (!nrst_in)
        $rose(done_out) |-> $past(dq_out, 2) == `CMD_RESET;
    endproperty
    a_reset_before_done: assert property (p_reset_before_done) // R03
        else $error("done without reset command");

    property p_byte_addr_even;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (!oe_n_out && byte_mode_in) |-> (addr_out[0] == 1'b0);
    endproperty
    a_byte_addr_even: assert property (p_byte_addr_even) // R24
        else $error("odd byte address in query read");

    property p_byte_high_zero;
        @(posedge core_clk_in) disable iff (!nrst_in)
        (tbl.wr_en && byte_mode_in) |-> (tbl.wr_data[15:8] == 8'h00);
    endproperty
    a_byte_high_zero: assert property (p_byte_high_zero) // R24
        else $error("high byte stored in byte mode");

    property p_walk_range;
        @(posedge core_clk_in) disable iff (!nrst_in)
        tbl.wr_en |-> (idx_reg >= `QUERY_FIRST && idx_reg <= `QUERY_LAST);
    endproperty
    a_walk_range: assert property (p_walk_range) // R06
        else $error("entry outside the query table");

    property p_done_pulse;
        @(posedge core_clk_in) disable iff (!nrst_in)
        done_out |=> !done_out ##1 !busy_out;
    endproperty
    a_done_pulse: assert property (p_done_pulse) // R05
        else $error("done not a single pulse");
endmodule // cfi_query_host

// ==== bench/flash_query_model.sv ====
/*
 * Behavioural flash device in query mode: command decode on the rising
 * write strobe, query table on reads.
 * Assumes the bench resolves the shared data bus and presets the mode.
 */
`timescale 1ns/1ps
module flash_query_model (
    input  wire logic        preset_in,
    input  wire logic        preset_auto_in,
    input  wire logic        byte_mode_in,
    input  wire logic [19:0] addr_in,
    input  wire logic [15:0] dq_in,
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    output logic      [15:0] dq_out,
    output logic      [1:0]  mode_out
);
    localparam logic [1:0] MODE_ARRAY = 2'h0;
    localparam logic [1:0] MODE_AUTO  = 2'h1;
    localparam logic [1:0] MODE_QUERY = 2'h2;
    logic [1:0]  entry_reg;
    logic [15:0] last_reg = 16'h0000;
    logic [19:0] waddr;
    logic [19:0] cmd_addr;
    logic [15:0] rd_val;

    // Fixed query table; entries not listed read as zero
    function automatic logic [15:0] query_word(input logic [5:0] a);
        case (a)
            6'h10: query_word = 16'h0051;
            6'h11: query_word = 16'h0052;
            6'h12: query_word = 16'h0059;
            6'h13: query_word = 16'h0002;
            6'h15: query_word = 16'h0040;
            6'h1b: query_word = 16'h0027;
            6'h1c: query_word = 16'h0036;
            6'h1f: query_word = 16'h0004;
            6'h21: query_word = 16'h000a;
            6'h23: query_word = 16'h0005;
            6'h25: query_word = 16'h0004;
            6'h27: query_word = 16'h0014;
            6'h28: query_word = 16'h0002;
            6'h2c: query_word = 16'h0004;
            6'h2f: query_word = 16'h0040;
            6'h31: query_word = 16'h0001;
            6'h33: query_word = 16'h0020;
            6'h37: query_word = 16'h0080;
            6'h39: query_word = 16'h000e;
            6'h3c: query_word = 16'h0001;
            default: query_word = 16'h0000;
        endcase
    endfunction

    assign cmd_addr = byte_mode_in ? 20'h000aa : 20'h00055;

    // Commands land on the rising write strobe; anything unknown aborts
    always @(posedge we_n_in or posedge preset_in) begin
        if (preset_in) begin
            mode_out <= preset_auto_in ? MODE_AUTO : MODE_ARRAY;
        end else if (!ce_n_in && oe_n_in) begin
            if (dq_in[7:0] == 8'h98 && addr_in == cmd_addr &&
                mode_out != MODE_QUERY) begin
                entry_reg <= mode_out;
                mode_out  <= MODE_QUERY;
            end else if (dq_in[7:0] == 8'hf0) begin
                mode_out <= (mode_out == MODE_QUERY) ? entry_reg : MODE_ARRAY;
            end else begin
                mode_out <= MODE_ARRAY;
            end
        end
    end

    // Byte mode halves the address and keeps only the low byte valid
    always_comb begin
        waddr = byte_mode_in ? {1'b0, addr_in[19:1]} : addr_in;
        if (mode_out == MODE_QUERY)
            rd_val = (waddr[19:6] == 14'h0000) ? query_word(waddr[5:0])
                                               : 16'h0000;
        else if (mode_out == MODE_AUTO)
            rd_val = 16'h00c3;
        else
            rd_val = addr_in[15:0] ^ 16'h3c5a;
        if (byte_mode_in)
            rd_val[15:8] = ~last_reg[15:8];
    end

    // A released bus shows the inverse of the last value, never a hold
    assign dq_out = (!ce_n_in && !oe_n_in) ? rd_val : ~last_reg;
    always @(posedge oe_n_in) last_reg <= rd_val;
endmodule // flash_query_model

// ==== bench/flash_cfi_query_responder_test.sv ====
/*
 * Self-checking bench for the query host: walks the table against the
 * flash model in both address modes and both prior device modes.
 * Assumes the design files and the flash model are compiled first.
 */
`timescale 1ns/1ps
module flash_cfi_query_responder_test;
    logic        core_clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic        start_in = 1'b0;
    logic        byte_mode_in = 1'b0;
    logic        from_autoselect_in = 1'b0;
    logic [5:0]  rd_idx_in = 6'h00;
    logic        preset = 1'b0;
    logic        preset_auto = 1'b0;
    logic [15:0] host_dq, model_dq, rd_data;
    wire  [15:0] bus_dq;
    logic        dq_oe_n, ce_n, oe_n, we_n, busy, done, mode_ok;
    logic [19:0] addr;
    logic [1:0]  mode;
    int          errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    logic [7:0]  tbl [45] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h27, 8'h36, 8'h00, 8'h00,
        8'h04, 8'h00, 8'h0a, 8'h00, 8'h05, 8'h00, 8'h04, 8'h00, 8'h14,
        8'h02, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h40, 8'h00,
        8'h01, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h0e,
        8'h00, 8'h00, 8'h01};

    always #20 core_clk_in = ~core_clk_in;
    // Shared data bus: the host wins only while its enable is low
    assign bus_dq = dq_oe_n ? model_dq : host_dq;

    cfi_query_host uut (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .start_in(start_in), .byte_mode_in(byte_mode_in),
        .from_autoselect_in(from_autoselect_in), .rd_idx_in(rd_idx_in),
        .dq_in(bus_dq), .dq_out(host_dq), .dq_oe_n_out(dq_oe_n),
        .addr_out(addr), .ce_n_out(ce_n), .oe_n_out(oe_n), .we_n_out(we_n),
        .busy_out(busy), .done_out(done), .mode_ok_out(mode_ok),
        .rd_data_out(rd_data));
    flash_query_model flash (.preset_in(preset),
        .preset_auto_in(preset_auto), .byte_mode_in(byte_mode_in),
        .addr_in(addr), .dq_in(bus_dq), .ce_n_in(ce_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .dq_out(model_dq), .mode_out(mode));

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h want %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic final_report;
        if (errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Stored entries read back in a random rotation of the index order
    task automatic readback;
        int off;
        logic [5:0] i;
        off = $urandom % 45;
        for (int k = 0; k < 45; k++) begin
            i = 6'(16 + (k + off) % 45);
            @(posedge core_clk_in);
            rd_idx_in <= i;
            repeat (2) @(posedge core_clk_in);
            @(negedge core_clk_in);
            check(rd_data, {8'h00, tbl[i - 6'h10]}, "entry");
        end
    endtask

    // One full walk, with a second start thrown in while busy
    task automatic walk(input logic bm, input logic auto_mode);
        int n;
        n = 0;
        preset_auto = auto_mode;
        preset = 1'b1;
        #1 preset = 1'b0;
        @(posedge core_clk_in);
        byte_mode_in       <= bm;
        from_autoselect_in <= auto_mode;
        start_in           <= 1'b1;
        @(posedge core_clk_in);
        start_in <= 1'b0;
        repeat (20) @(posedge core_clk_in);
        start_in <= 1'b1;
        @(posedge core_clk_in);
        start_in <= 1'b0;
        do begin
            @(negedge core_clk_in);
            n++;
        end while (done !== 1'b1 && n < 2000);
        check(16'(n < 2000), 16'h0001, "walk end");
        check(16'(mode_ok), 16'h0001, "ident");
        check(16'(mode), 16'(auto_mode), "mode after");
        repeat (4) @(negedge core_clk_in);
        check(16'(busy), 16'h0000, "restart");
        readback();
    endtask

    // Every read cycle: device in query mode, high address bits zero
    always @(negedge core_clk_in) begin
        if (nrst_in && !ce_n && !oe_n) begin
            check(16'(addr >> (7 + byte_mode_in)), 16'h0000, "addr");
            check(16'(mode), 16'h0002, "query mode");
        end
    end

    // Hang guard: far above eight walks with readback
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        logic [1:0] r;
        void'($urandom(32'h7114));
        repeat (6) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        @(negedge core_clk_in);
        for (int c = 0; c < 4; c++)
            walk(c[0], c[1]);
        // Reset in mid-walk drops every strobe and the busy flag
        @(posedge core_clk_in);
        start_in <= 1'b1;
        @(posedge core_clk_in);
        start_in <= 1'b0;
        repeat (30) @(posedge core_clk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        @(negedge core_clk_in);
        check({10'h000, busy, done, dq_oe_n, ce_n, oe_n, we_n}, 16'h000f,
              "reset state");
        for (int k = 0; k < 4; k++) begin
            r = 2'($urandom);
            walk(r[0], r[1]);
        end
        final_report();
    end
endmodule // flash_cfi_query_responder_test
